// ---- common/tfi_pkg.sv ----
// Shared constants for the transceiver fabric interface block.
// Assumes one reference clock; channel parallel clocks are enables.
package tfi_pkg;

	// Channel count, default parallel-rate divider and FIFO depth
	localparam int NCH_DEF     = 4;
	localparam int PAR_DIV_DEF = 4;
	localparam int FIFO_DEPTH  = 4;

	// Reference clock
	localparam real REF_PERIOD_NS = 8.0;

	// Receive word layout, 20-bit fabric mode, 10-bit symbols
	localparam int SYM_W      = 10;
	localparam int HALF_W     = 16;
	localparam int WORD_W     = 32;
	localparam int TXW_W      = 20;
	localparam int LO_SYM     = 0;
	localparam int HI_SYM     = 16;
	localparam int POS_SYNC   = 10;
	localparam int POS_DERR   = 11;
	localparam int POS_PDET   = 12;
	localparam int POS_RMDEL  = 13;
	localparam int POS_RMINS  = 14;
	localparam int POS_RDISP  = 15;

	// Reset values
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [19:0] TXW_RST  = 20'h0_0000;

	// Receive core clock selection
	typedef enum logic [1:0] {
		TFI_RX_SHARED_TX0 = 2'h0,
		TFI_RX_OWN_TX     = 2'h1,
		TFI_RX_OWN_RX     = 2'h2
	} tfi_rx_sel_t;

endpackage

// ---- hw/tfi_pcf_fifo.sv ----
// Phase-compensation FIFO between two equal-rate clock enables.
// Assumes both enables come from the same clock domain.
`timescale 1ns/100ps
module tfi_pcf_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_data,
	input  wire logic         rd_en,
	output logic      [W-1:0] rd_data,
	output logic              rd_valid,
	output logic              overflow,
	output logic              underflow
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	logic          run_q;
	logic          do_wr;
	logic          do_rd;

	// Writes drop when full with no read that cycle, reads wait for half fill, then stall on empty
	assign do_wr = wr_en && (cnt_q != FULL || do_rd);
	assign do_rd = rd_en && run_q && cnt_q != '0;

	// Storage
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wp_q] <= wr_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (do_wr) begin
				wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			end
			if (do_rd) begin
				rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end

	// Reading starts once half full, centring the phase margin
	always_ff @(posedge clk) begin
		if (rst) begin
			run_q <= 1'b0;
		end else if (cnt_q >= HALF) begin
			run_q <= 1'b1;
		end
	end

	// Output word and status pulses
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data   <= '0;
			rd_valid  <= 1'b0;
			overflow  <= 1'b0;
			underflow <= 1'b0;
		end else begin
			rd_valid  <= do_rd;
			overflow  <= wr_en && !do_wr;
			underflow <= rd_en && run_q && cnt_q == '0;
			if (do_rd) begin
				rd_data <= mem[rp_q];
			end
		end
	end
endmodule // tfi_pcf_fifo

// ---- hw/tfi_core.sv ----
// Fabric side of a multi-channel transceiver block: receive word
// packing, core clock selection and phase-compensation FIFOs.
// Assumes fabric core clocks arrive on pins, unrelated to REF_CLK.
`timescale 1ns/100ps
module tfi_core #(
	parameter int NCH     = tfi_pkg::NCH_DEF,
	parameter int PAR_DIV = tfi_pkg::PAR_DIV_DEF
) (
	input  wire logic              REF_CLK,
	input  wire logic              RST,
	input  wire logic              PIPE_MODE,
	input  wire logic              TX_SHARED,
	input  wire logic [1:0]        RX_CLK_SEL,
	input  wire logic [NCH-1:0]    RX_HALF_RATE,
	input  wire logic [NCH-1:0]    TX_CORECLK_USE,
	input  wire logic [NCH-1:0]    TX_CORECLK,
	input  wire logic [NCH-1:0]    RX_CORECLK_USE,
	input  wire logic [NCH-1:0]    RX_CORECLK,
	input  wire logic [NCH*20-1:0] TX_DATAIN,
	input  wire logic [NCH*20-1:0] RX_SYM,
	input  wire logic [NCH*2-1:0]  RX_SYNC,
	input  wire logic [NCH*2-1:0]  RX_DISPERR,
	input  wire logic [NCH*2-1:0]  RX_PATDET,
	input  wire logic [NCH*2-1:0]  RX_RMDEL,
	input  wire logic [NCH*2-1:0]  RX_RMINS,
	input  wire logic [NCH*4-1:0]  RX_PIPESTAT,
	input  wire logic [NCH*2-1:0]  RX_RDISP,
	output logic      [NCH-1:0]    TX_CLKOUT,
	output logic      [NCH-1:0]    RX_CLKOUT,
	output logic      [NCH*20-1:0] TX_PMA_DATA,
	output logic      [NCH-1:0]    TX_PMA_VALID,
	output logic      [NCH*32-1:0] RX_DATAOUT,
	output logic      [NCH-1:0]    RX_DATA_VALID,
	output logic      [NCH-1:0]    TX_FIFO_OVF,
	output logic      [NCH-1:0]    TX_FIFO_UNF,
	output logic      [NCH-1:0]    RX_FIFO_OVF,
	output logic      [NCH-1:0]    RX_FIFO_UNF
);
	localparam int DW = $clog2(2 * PAR_DIV);
	localparam logic [DW-1:0] DIV_LAST  = DW'(PAR_DIV - 1);
	localparam logic [DW-1:0] DIV2_LAST = DW'(2 * PAR_DIV - 1);

	// Packs one half of the 20-bit mode receive word
	function automatic logic [15:0] pack_half(
		input logic [9:0] sym,
		input logic       sync,
		input logic       derr,
		input logic       pdet,
		input logic       del,
		input logic       ins,
		input logic [1:0] pstat,
		input logic       rdisp,
		input logic       pipe
	);
		logic [15:0] h;
		h                      = '0;
		h[9:0]                 = sym;
		h[tfi_pkg::POS_SYNC]   = sync;
		h[tfi_pkg::POS_DERR]   = derr;
		h[tfi_pkg::POS_PDET]   = pdet;
		h[tfi_pkg::POS_RMDEL]  = pipe ? pstat[0] : del;
		h[tfi_pkg::POS_RMINS]  = pipe ? pstat[1] : ins;
		h[tfi_pkg::POS_RDISP]  = rdisp;
		return h;
	endfunction

	logic [NCH-1:0] tx_par_en;
	logic [NCH-1:0] rx_par_en;
	logic [NCH-1:0] tx_wr_en;
	logic [NCH-1:0] rx_rd_en;
	logic [NCH-1:0] txc_s1_q;
	logic [NCH-1:0] txc_s2_q;
	logic [NCH-1:0] txc_s3_q;
	logic [NCH-1:0] rxc_s1_q;
	logic [NCH-1:0] rxc_s2_q;
	logic [NCH-1:0] rxc_s3_q;
	tfi_pkg::tfi_rx_sel_t rx_sel;

	assign rx_sel = tfi_pkg::tfi_rx_sel_t'(RX_CLK_SEL);

	// Fabric core clock pins: two-stage synchronisers, then edge stage.
	// Not reset, so a pin held high across reset gives no false edge.
	always_ff @(posedge REF_CLK) begin
		txc_s1_q <= TX_CORECLK;
		txc_s2_q <= txc_s1_q;
		txc_s3_q <= txc_s2_q;
		rxc_s1_q <= RX_CORECLK;
		rxc_s2_q <= rxc_s1_q;
		rxc_s3_q <= rxc_s2_q;
	end

	assign TX_CLKOUT = tx_par_en;
	assign RX_CLKOUT = rx_par_en;

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		localparam logic [DW-1:0] PH = DW'(c % PAR_DIV);
		logic [DW-1:0] txd_q;
		logic [DW-1:0] rxd_q;
		logic [DW-1:0] rx_last;
		logic [31:0]   rx_word;
		logic [19:0]   tx_word;
		logic          tx_core_rise;
		logic          rx_core_rise;
		logic          rx_src_en;

		// Transmit parallel clock: fixed rate, divider never touches it
		always_ff @(posedge REF_CLK) begin
			if (RST) begin
				txd_q <= PH;
			end else begin
				txd_q <= (txd_q >= DIV_LAST) ? '0 : txd_q + 1'b1;
			end
		end
		assign tx_par_en[c] = (txd_q == DIV_LAST);

		// Receive parallel clock with local divide-by-two
		assign rx_last = RX_HALF_RATE[c] ? DIV2_LAST : DIV_LAST;
		always_ff @(posedge REF_CLK) begin
			if (RST) begin
				rxd_q <= PH;
			end else begin
				rxd_q <= (rxd_q >= rx_last) ? '0 : rxd_q + 1'b1;
			end
		end
		assign rx_par_en[c] = (rxd_q == rx_last);

		// Rising edges of the fabric-supplied core clocks
		assign tx_core_rise = txc_s2_q[c] && !txc_s3_q[c];
		assign rx_core_rise = rxc_s2_q[c] && !rxc_s3_q[c];

		// Transmit FIFO write clock selection
		always_comb begin
			if (TX_CORECLK_USE[c]) begin
				tx_wr_en[c] = tx_core_rise;
			end else if (TX_SHARED) begin
				tx_wr_en[c] = tx_par_en[0];
			end else begin
				tx_wr_en[c] = tx_par_en[c];
			end
		end

		// Receive FIFO read clock selection
		always_comb begin
			unique case (rx_sel)
				tfi_pkg::TFI_RX_SHARED_TX0: rx_src_en = tx_par_en[0];
				tfi_pkg::TFI_RX_OWN_TX:     rx_src_en = tx_par_en[c];
				tfi_pkg::TFI_RX_OWN_RX:     rx_src_en = rx_par_en[c];
				default:                    rx_src_en = rx_par_en[c];
			endcase
			rx_rd_en[c] = RX_CORECLK_USE[c] ? rx_core_rise
				: rx_src_en;
		end

		// Receive word packing, lower then upper symbol
		assign rx_word = {
			pack_half(RX_SYM[c*20+10 +: 10], RX_SYNC[c*2+1],
				RX_DISPERR[c*2+1], RX_PATDET[c*2+1], RX_RMDEL[c*2+1],
				RX_RMINS[c*2+1], RX_PIPESTAT[c*4+2 +: 2], RX_RDISP[c*2+1],
				PIPE_MODE),
			pack_half(RX_SYM[c*20 +: 10], RX_SYNC[c*2], RX_DISPERR[c*2],
				RX_PATDET[c*2], RX_RMDEL[c*2], RX_RMINS[c*2],
				RX_PIPESTAT[c*4 +: 2], RX_RDISP[c*2], PIPE_MODE)};

		// Transmit FIFO: fabric writes on core clock, PMA reads
		tfi_pcf_fifo #(
			.W     (tfi_pkg::TXW_W),
			.DEPTH (tfi_pkg::FIFO_DEPTH)
		) u_tx_fifo (
			.clk       (REF_CLK),
			.rst       (RST),
			.wr_en     (tx_wr_en[c]),
			.wr_data   (TX_DATAIN[c*20 +: 20]),
			.rd_en     (tx_par_en[c]),
			.rd_data   (tx_word),
			.rd_valid  (TX_PMA_VALID[c]),
			.overflow  (TX_FIFO_OVF[c]),
			.underflow (TX_FIFO_UNF[c])
		);
		assign TX_PMA_DATA[c*20 +: 20] = tx_word;

		// Receive FIFO: PMA writes, fabric reads on core clock
		tfi_pcf_fifo #(
			.W     (tfi_pkg::WORD_W),
			.DEPTH (tfi_pkg::FIFO_DEPTH)
		) u_rx_fifo (
			.clk       (REF_CLK),
			.rst       (RST),
			.wr_en     (rx_par_en[c]),
			.wr_data   (rx_word),
			.rd_en     (rx_rd_en[c]),
			.rd_data   (RX_DATAOUT[c*32 +: 32]),
			.rd_valid  (RX_DATA_VALID[c]),
			.overflow  (RX_FIFO_OVF[c]),
			.underflow (RX_FIFO_UNF[c])
		);

		// Full-rate receive period: one strobe every PAR_DIV cycles
		sequence full_gap_s;
			(!rx_par_en[c])[*3] ##1 rx_par_en[c];
		endsequence
		// Half-rate receive period: twice as long
		sequence half_gap_s;
			(!rx_par_en[c])[*7] ##1 rx_par_en[c];
		endsequence

		sym_lo_pack_a: assert property (@(posedge REF_CLK) disable iff (RST)
			rx_word[9:0] == RX_SYM[c*20 +: 10]
			&& rx_word[25:16] == RX_SYM[c*20+10 +: 10])
			else $error("symbol placement wrong");
		sync_flag_pos_a: assert property (@(posedge REF_CLK) disable iff (RST)
			rx_word[10] == RX_SYNC[c*2] && rx_word[26] == RX_SYNC[c*2+1])
			else $error("sync flag placement wrong");
		derr_flag_pos_a: assert property (@(posedge REF_CLK) disable iff (RST)
			{rx_word[27], rx_word[11]} == RX_DISPERR[c*2 +: 2])
			else $error("disparity error placement wrong");
		pdet_flag_pos_a: assert property (@(posedge REF_CLK) disable iff (RST)
			{rx_word[28], rx_word[12]} == RX_PATDET[c*2 +: 2])
			else $error("pattern detect placement wrong");
		rm_del_pos_a: assert property (@(posedge REF_CLK) disable iff (RST)
			!PIPE_MODE |-> {rx_word[29], rx_word[13]} == RX_RMDEL[c*2 +: 2])
			else $error("deletion flag placement wrong");
		rm_ins_pos_a: assert property (@(posedge REF_CLK) disable iff (RST)
			!PIPE_MODE |-> {rx_word[30], rx_word[14]} == RX_RMINS[c*2 +: 2])
			else $error("insertion flag placement wrong");
		rdisp_pos_a: assert property (@(posedge REF_CLK) disable iff (RST)
			{rx_word[31], rx_word[15]} == RX_RDISP[c*2 +: 2])
			else $error("running disparity placement wrong");
		rx_half_rate_a: assert property (@(posedge REF_CLK) disable iff (RST)
			rx_par_en[c] && RX_HALF_RATE[c] |=> half_gap_s)
			else $error("half-rate strobe spacing wrong");
		rx_full_rate_a: assert property (@(posedge REF_CLK) disable iff (RST)
			rx_par_en[c] && !RX_HALF_RATE[c] |=> full_gap_s)
			else $error("full-rate strobe spacing wrong");
		tx_rate_fixed_a: assert property (@(posedge REF_CLK) disable iff (RST)
			tx_par_en[c] |=> (!tx_par_en[c])[*3] ##1 tx_par_en[c])
			else $error("transmit rate moved with divider");
		tx_shared_wr_a: assert property (@(posedge REF_CLK) disable iff (RST)
			TX_SHARED && !TX_CORECLK_USE[c] |-> tx_wr_en[c] == tx_par_en[0])
			else $error("shared transmit write clock wrong");
		rx_own_rd_a: assert property (@(posedge REF_CLK) disable iff (RST)
			rx_sel == tfi_pkg::TFI_RX_OWN_RX && !RX_CORECLK_USE[c]
			&& rx_rd_en[c] |-> rx_par_en[c])
			else $error("own receive read clock wrong");
	end
endmodule // tfi_core

// ---- dv/tfi_fabric_model.sv ----
// Fabric user logic model: transmit words and receive core clocks.
// Assumes an 8 ns reference clock; words change on its falling edge.
`timescale 1ns/100ps
module tfi_fabric_model (
	input  wire logic        ref_clk,
	output logic      [79:0] tx_data,
	output logic      [3:0]  rx_coreclk,
	output logic      [3:0]  tx_coreclk,
	output logic      [19:0] cyc
);
	// Every channel sends the cycle number, so a capture shows its edge
	initial cyc = 20'h0_0000;
	always @(negedge ref_clk) begin
		cyc <= cyc + 20'h0_0001;
	end
	assign tx_data = {4{cyc}};
	// Core clock at the half-rate receive parallel rate, free running
	initial rx_coreclk = 4'h0;
	always #32 rx_coreclk = ~rx_coreclk;
	// Core clock at the full transmit parallel rate, rising at 16+32k ns
	initial tx_coreclk = 4'h0;
	always #16 tx_coreclk = ~tx_coreclk;
endmodule // tfi_fabric_model

// ---- dv/tfi_core_tb_top.sv ----
// Testbench for the transceiver fabric interface block.
// Assumes the default four channels and parallel divider of four.
`timescale 1ns/100ps
module tfi_core_tb_top;
	logic         ref_clk = 1'b0;
	logic         rst = 1'b1;
	logic         pipe = 1'b0;
	logic         tx_sh = 1'b0;
	logic         chk_on = 1'b0;
	logic [1:0]   rx_sel = 2'h0;
	logic [3:0]   half = 4'h0;
	logic [3:0]   rx_use = 4'h0;
	logic [3:0]   tx_use = 4'h0;
	logic [3:0]   tx_cclk;
	logic [3:0]   rx_cclk, tx_clk, rx_clk, tx_val, rx_val, st_tx, st_rx;
	logic [3:0]   tovf, tunf, rovf, runf;
	logic [79:0]  tx_din, tx_pma, rx_sym;
	logic [127:0] rx_out;
	logic [7:0]   f = 8'h00;
	logic [7:0]   sync, derr, pdet, del, ins, rdisp;
	logic [15:0]  pstat;
	logic [19:0]  cyc;
	logic [1:0]   ph [4];
	int           error_cnt = 0;
	int           samples_checked = 0;
	int           n_tx [4];
	int           n_rx [4];

	// Clock
	always #4 ref_clk = ~ref_clk;

	// Receive status flags, each vector distinct
	assign sync = f;
	assign derr = ~f;
	assign pdet = f ^ 8'h33;
	assign del = f ^ 8'h0f;
	assign ins = f ^ 8'hf0;
	assign rdisp = f ^ 8'h3c;
	assign pstat = {~f, f};
	assign rx_sym = {f, f ^ 8'h5a, f, ~f, f, f ^ 8'h33, f ^ 8'hc3, f, ~f, f};

	tfi_fabric_model fab (.ref_clk(ref_clk), .tx_data(tx_din),
		.rx_coreclk(rx_cclk), .tx_coreclk(tx_cclk), .cyc(cyc));

	tfi_core dut (.REF_CLK(ref_clk), .RST(rst), .PIPE_MODE(pipe),
		.TX_SHARED(tx_sh), .RX_CLK_SEL(rx_sel), .RX_HALF_RATE(half),
		.TX_CORECLK_USE(tx_use), .TX_CORECLK(tx_cclk),
		.RX_CORECLK_USE(rx_use), .RX_CORECLK(rx_cclk),
		.TX_DATAIN(tx_din), .RX_SYM(rx_sym), .RX_SYNC(sync),
		.RX_DISPERR(derr), .RX_PATDET(pdet), .RX_RMDEL(del),
		.RX_RMINS(ins), .RX_PIPESTAT(pstat), .RX_RDISP(rdisp),
		.TX_CLKOUT(tx_clk), .RX_CLKOUT(rx_clk), .TX_PMA_DATA(tx_pma),
		.TX_PMA_VALID(tx_val), .RX_DATAOUT(rx_out),
		.RX_DATA_VALID(rx_val), .TX_FIFO_OVF(tovf), .TX_FIFO_UNF(tunf),
		.RX_FIFO_OVF(rovf), .RX_FIFO_UNF(runf));

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Packed receive word from the inputs now applied
	function automatic logic [31:0] exp_word(input int c);
		logic [31:0] w;
		int          i;
		for (int h = 0; h < 2; h++) begin
			i = c * 2 + h;
			w[h*16+:10] = rx_sym[c*20+h*10+:10];
			w[h*16+10] = sync[i];
			w[h*16+11] = derr[i];
			w[h*16+12] = pdet[i];
			w[h*16+13] = pipe ? pstat[c*4+h*2] : del[i];
			w[h*16+14] = pipe ? pstat[c*4+h*2+1] : ins[i];
			w[h*16+15] = rdisp[i];
		end
		return w;
	endfunction

	// Monitor: strobe phases, captured words, fault pulses
	always @(negedge ref_clk) begin
		#1;
		for (int c = 0; c < 4; c++) begin
			if (chk_on && tx_val[c])
				// Core pin rise plus sync latency lands on a cycle count of 4k
				check(tx_pma[c*20+:2], tx_use[c] ? 2'h0 : ph[tx_sh ? 0 : c]);
			if (chk_on && rx_val[c]) begin
				check(rx_out[c*32+:32], exp_word(c));
				if (!rx_use[c])
					check(rx_sel == 2'h0 ? st_tx[0] : rx_sel == 2'h1 ? st_tx[c] : st_rx[c], 1'b1);
			end
			if (chk_on)
				check({tovf[c], tunf[c], rovf[c], runf[c]}, 4'h0);
			if (tx_clk[c])
				ph[c] = cyc[1:0];
			n_tx[c] += tx_clk[c];
			n_rx[c] += rx_clk[c];
		end
		st_tx = tx_clk;
		st_rx = rx_clk;
	end

	// One configuration: reset, settle, watch, count strobes
	task automatic run_mode(input logic [1:0] sel, input logic sh, pp,
		input logic [3:0] hr, use_rx, use_tx, input logic [7:0] fl);
		@(negedge ref_clk);
		chk_on = 1'b0;
		rst = 1'b1;
		rx_sel = sel;
		tx_sh = sh;
		pipe = pp;
		half = hr;
		rx_use = use_rx;
		tx_use = use_tx;
		f = fl;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		repeat (24) @(negedge ref_clk);
		n_tx = '{default: 0};
		n_rx = '{default: 0};
		chk_on = 1'b1;
		repeat (64) @(negedge ref_clk);
		chk_on = 1'b0;
		for (int c = 0; c < 4; c++) begin
			check(n_tx[c], 16);
			check(n_rx[c], hr[c] ? 8 : 16);
		end
	endtask

	// Verdict and end of run
	task automatic wrap_up;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		run_mode(2'h0, 1'b1, 1'b0, 4'h0, 4'h0, 4'h0, 8'ha5);
		run_mode(2'h1, 1'b0, 1'b1, 4'h0, 4'h0, 4'h2, 8'h3c);
		run_mode(2'h2, 1'b0, 1'b0, 4'h5, 4'h0, 4'h0, 8'h96);
		run_mode(2'h2, 1'b1, 1'b1, 4'hc, 4'h8, 4'h0, 8'h5f);
		wrap_up();
	end

	// Watchdog, well past the expected length of the run
	initial begin
		repeat (2000) @(posedge ref_clk);
		error_cnt++;
		wrap_up();
	end
endmodule // tfi_core_tb_top
